// >>> rtl/ppss_sequencer.v
// operating state sequencer with apb register slave
//
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ppss_defs.vh"
module ppss_sequencer #(
  parameter integer SLEEP_REQ_CYC = (`PPSS_CLK_HZ / 1000000) * `PPSS_SLEEP_REQ_US,
  parameter integer SILENT_CYC    = (`PPSS_CLK_HZ / 1000000) * `PPSS_SILENT_US,
  parameter integer CNT_W         = 20
) (
  // clock and reset
  input  wire        i_mclk,
  input  wire        i_rst_n,
  // apb slave
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [12:0] i_paddr,
  input  wire [31:0] i_pwdata,
  output wire        o_pready,
  output reg  [31:0] o_prdata,
  output wire        o_pslverr,
  // device pins (asynchronous)
  input  wire        i_supply_ok,
  input  wire        i_enable_pin,
  input  wire        i_wake_pin,
  input  wire        i_strap_auto,
  input  wire        i_strap_master,
  // line and mac side events (asynchronous)
  input  wire        i_line_energy,
  input  wire        i_line_quiet,
  input  wire        i_rx_sleep_codes,
  input  wire        i_frame_seen,
  // controls to datapath
  output reg         o_io_oe_n,
  output reg         o_analog_en,
  output reg         o_term_en,
  output reg         o_coding_en,
  output reg         o_send_sleep_codes,
  output reg         o_send_zero,
  output reg         o_scr_stream2,
  output reg         o_energy_det_en,
  output reg         o_is_master,
  output reg  [2:0]  o_state
);
  // ==================================================
  // states
  localparam [2:0] ST_DOWN   = 3'h0;
  localparam [2:0] ST_STBY   = 3'h1;
  localparam [2:0] ST_NORMAL = 3'h2;
  localparam [2:0] ST_SREQ   = 3'h3;
  localparam [2:0] ST_SILENT = 3'h4;
  localparam [2:0] ST_SLEEP  = 3'h5;
  localparam [2:0] ST_RESET  = 3'h6;
  localparam [31:0]      SREQ_LAST_W = SLEEP_REQ_CYC - 1;
  localparam [31:0]      SIL_LAST_W  = SILENT_CYC - 1;
  localparam [CNT_W-1:0] SREQ_LAST   = SREQ_LAST_W[CNT_W-1:0];
  localparam [CNT_W-1:0] SIL_LAST    = SIL_LAST_W[CNT_W-1:0];
  // ==================================================
  // pin synchronisation
  wire [8:0] pins_s;
  ppss_sync #(
    .WIDTH (9)
  ) u_sync (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_async ({i_supply_ok, i_enable_pin, i_wake_pin, i_strap_auto, i_strap_master,
               i_line_energy, i_line_quiet, i_rx_sleep_codes, i_frame_seen}),
    .o_sync  (pins_s)
  );
  wire supply_s = pins_s[8];
  wire en_s     = pins_s[7];
  wire wake_s   = pins_s[6];
  wire strap_a  = pins_s[5];
  wire strap_m  = pins_s[4];
  wire energy_s = pins_s[3];
  wire quiet_s  = pins_s[2];
  wire rxlps_s  = pins_s[1];
  wire frame_s  = pins_s[0];
  // ==================================================
  // registers
  reg  [2:0]       state_reg;
  reg  [2:0]       state_next;
  reg  [CNT_W-1:0] cnt_reg;
  reg  [CNT_W-1:0] cnt_next;
  reg  [15:0]      auto_reg;
  reg  [15:0]      sleep_cfg_reg;
  reg              force_normal_reg;
  reg              sleep_req_reg;
  reg              strap_auto_reg;
  reg              strap_master_reg;
  reg              soft_rst_reg;
  wire             off_cond = !supply_s || !en_s;
  wire             bus_ok   = (state_reg != ST_SLEEP) && (state_reg != ST_DOWN)
                              && (state_reg != ST_RESET);
  wire             wr_acc   = i_psel && i_penable && i_pwrite && bus_ok;
  wire             auto_on  = auto_reg[`PPSS_BIT_AUTO_MODE];
  wire             cfg_clr  = (state_next == ST_SLEEP) || (state_next == ST_RESET)
                              || (state_next == ST_DOWN);
  function known_addr;
    input [12:0] a;
    begin
      known_addr = (a == `PPSS_ADDR_RESET_CTRL) || (a == `PPSS_ADDR_AUTO_CTRL)
                   || (a == `PPSS_ADDR_POWER_MODE) || (a == `PPSS_ADDR_SLEEP_CFG)
                   || (a == `PPSS_ADDR_STATUS);
    end
  endfunction
  // apb answers in the access phase; refused while asleep or in reset
  assign o_pready  = 1'b1;
  assign o_pslverr = i_psel && i_penable && (!bus_ok || !known_addr(i_paddr));
  // ==================================================
  // next state
  always @*
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    case (state_reg)
      ST_DOWN:
        state_next = ST_RESET;
      ST_RESET:
        // reset lasts one cycle: decide from the live strap, captured at this same edge
        if (strap_a || auto_on)
          state_next = ST_NORMAL;
        else
          state_next = ST_STBY;
      ST_STBY:
        if (auto_on || force_normal_reg || energy_s)
          state_next = ST_NORMAL;
      ST_NORMAL:
        if (sleep_req_reg || rxlps_s)
        begin
          state_next = ST_SREQ;
          cnt_next   = {CNT_W{1'b0}};
        end
      ST_SREQ:
        if (force_normal_reg || frame_s)
          state_next = ST_NORMAL;
        else if (((cnt_reg >= SREQ_LAST) || quiet_s) && !wake_s)
        begin
          state_next = ST_SILENT;
          cnt_next   = {CNT_W{1'b0}};
        end
      ST_SILENT:
        if (energy_s)
          state_next = ST_STBY;
        else if (cnt_reg >= SIL_LAST)
          state_next = auto_reg[`PPSS_BIT_SLEEP_EN] ? ST_SLEEP : ST_STBY;
      ST_SLEEP:
        if (wake_s || energy_s)
          state_next = ST_RESET;
      default:
        state_next = ST_RESET;
    endcase
    if (off_cond)
      state_next = ST_DOWN;
    else if (soft_rst_reg && state_reg != ST_DOWN)
      state_next = ST_RESET;
  end
  // ==================================================
  // state and counter
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      state_reg <= ST_RESET;
      cnt_reg   <= {CNT_W{1'b0}};
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end
  // ==================================================
  // straps: captured by the clock while in reset
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      strap_auto_reg   <= 1'b0;
      strap_master_reg <= 1'b0;
    end
    else if (state_reg == ST_RESET)
    begin
      strap_auto_reg   <= strap_a;
      strap_master_reg <= strap_m;
    end
  end
  // ==================================================
  // software registers
  always @(posedge i_mclk)
  begin
    if (!i_rst_n || cfg_clr)
    begin
      auto_reg         <= `PPSS_AUTO_RESET;
      sleep_cfg_reg    <= `PPSS_SLEEP_CFG_RESET;
      force_normal_reg <= 1'b0;
      sleep_req_reg    <= 1'b0;
      soft_rst_reg     <= 1'b0;
    end
    else
    begin
      // command bits self-clear once the state acts on them
      if (state_reg == ST_NORMAL || state_reg == ST_SREQ)
        force_normal_reg <= 1'b0;
      if (state_reg == ST_SREQ)
        sleep_req_reg <= 1'b0;
      if (wr_acc)
      begin
        case (i_paddr)
          `PPSS_ADDR_RESET_CTRL:
            soft_rst_reg <= i_pwdata[`PPSS_BIT_SOFT_RESET];
          `PPSS_ADDR_AUTO_CTRL:
            auto_reg <= i_pwdata[15:0];
          `PPSS_ADDR_POWER_MODE:
          begin
            if (i_pwdata[`PPSS_BIT_FORCE_NORMAL])
              force_normal_reg <= 1'b1;
            if (i_pwdata[`PPSS_BIT_SLEEP_REQ] && auto_reg[`PPSS_BIT_TX_EN])
              sleep_req_reg <= 1'b1;
          end
          `PPSS_ADDR_SLEEP_CFG:
            sleep_cfg_reg <= i_pwdata[15:0];
          default:
            ;
        endcase
      end
    end
  end
  // ==================================================
  // read data
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
      o_prdata <= 32'h00000000;
    else if (i_psel && !i_penable && !i_pwrite && bus_ok)
    begin
      o_prdata <= 32'h00000000;
      if (i_paddr == `PPSS_ADDR_SLEEP_CFG)
        o_prdata <= {16'h0000, sleep_cfg_reg};
      else if (i_paddr == `PPSS_ADDR_AUTO_CTRL)
        o_prdata <= {16'h0000, auto_reg};
      else if (i_paddr == `PPSS_ADDR_POWER_MODE)
        o_prdata <= {30'h00000000, sleep_req_reg, force_normal_reg};
      else if (i_paddr == `PPSS_ADDR_STATUS)
        o_prdata <= {24'h000000, strap_master_reg, strap_auto_reg, 3'h0, state_reg};
    end
  end
  // ==================================================
  // datapath controls, registered from the next state; scrambler stream from the sleep config, master from the strap
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      o_io_oe_n          <= 1'b1;
      o_analog_en        <= 1'b0;
      o_term_en          <= 1'b0;
      o_coding_en        <= 1'b0;
      o_send_sleep_codes <= 1'b0;
      o_send_zero        <= 1'b0;
      o_scr_stream2      <= 1'b0;
      o_energy_det_en    <= 1'b0;
      o_is_master        <= 1'b0;
      o_state            <= ST_RESET;
    end
    else
    begin
      o_io_oe_n          <= (state_next == ST_DOWN);
      o_analog_en        <= (state_next != ST_DOWN) && (state_next != ST_SLEEP);
      o_term_en          <= (state_next != ST_DOWN) && (state_next != ST_RESET)
                            && (state_next != ST_SLEEP);
      o_coding_en        <= (state_next == ST_NORMAL) || (state_next == ST_SREQ)
                            || (state_next == ST_SILENT);
      o_send_sleep_codes <= (state_next == ST_SREQ);
      o_send_zero        <= (state_next == ST_SILENT);
      o_scr_stream2      <= (sleep_cfg_reg[`PPSS_SCR_HI:`PPSS_SCR_LO]
                             == `PPSS_SCR_STREAM2);
      o_energy_det_en    <= (state_next != ST_DOWN) && (state_next != ST_RESET);
      o_is_master        <= strap_master_reg;
      o_state            <= state_next;
    end
  end
endmodule // ppss_sequencer
`default_nettype wire

// >>> rtl/ppss_defs.vh
// constants for the phy power state sequencer
// Contract
// - supply low: outputs high-z, analog off
// - reset on power-up, pin, soft bit 15
// - resample straps when reset ends
// - no termination in reset, power-down, disable
// - enable pin low acts as power-down
// - managed master enters standby after reset
// - standby: coding/media off, registers kept
// - autonomous strap goes straight to normal
// - host command releases standby to normal
// - autonomous bit 6 honoured by device
// - sleep request sends sleep notice codes
// - sleep request starts 1 ms timer
// - silent on timer expiry or quiet line
// - frame during sleep request returns normal
// - silent transmits zero symbol pairs
// - sleep enable plus quiet 8 ms: sleep
// - energy in silent goes to standby
// - sleep enable clear: standby; resets set
// - sleep: only energy detect, bus refused
// - sleep discards register configuration
// - sleep codes use second scrambler stream; the code selects it only when sleep config bits 9:8 are 3, whatever the state
// - wake pin or energy leaves sleep
// - power mode bit 0 forces normal
// - power mode bit 1 starts sleep request
// - received sleep codes enter sleep request
// - silent entry only with wake pin low
`ifndef PPSS_DEFS_VH
`define PPSS_DEFS_VH
// ==================================================
// register indices; the byte address is four times the index
`define PPSS_IDX_RESET_CTRL   13'h001f
`define PPSS_IDX_AUTO_CTRL    13'h018b
`define PPSS_IDX_POWER_MODE   13'h018c
`define PPSS_IDX_SLEEP_CFG    13'h04e5
`define PPSS_IDX_STATUS       13'h0200
// register byte addresses, full 13-bit width so the highest one is not cut
`define PPSS_ADDR_RESET_CTRL  (`PPSS_IDX_RESET_CTRL << 2)
`define PPSS_ADDR_AUTO_CTRL   (`PPSS_IDX_AUTO_CTRL << 2)
`define PPSS_ADDR_POWER_MODE  (`PPSS_IDX_POWER_MODE << 2)
`define PPSS_ADDR_SLEEP_CFG   (`PPSS_IDX_SLEEP_CFG << 2)
`define PPSS_ADDR_STATUS      (`PPSS_IDX_STATUS << 2)
// ==================================================
// field positions
`define PPSS_BIT_SOFT_RESET   15
`define PPSS_BIT_AUTO_MODE    6
`define PPSS_BIT_SLEEP_EN     1
`define PPSS_BIT_TX_EN        0
`define PPSS_BIT_FORCE_NORMAL 0
`define PPSS_BIT_SLEEP_REQ    1
`define PPSS_SCR_LO           8
`define PPSS_SCR_HI           9
`define PPSS_SCR_STREAM2      2'h3
// ==================================================
// reset values
`define PPSS_AUTO_RESET       16'h0003
`define PPSS_SLEEP_CFG_RESET  16'h0000
// ==================================================
// timing
`define PPSS_CLK_HZ           100000000
`define PPSS_SLEEP_REQ_US     1000
`define PPSS_SILENT_US        8000
`define PPSS_STATE_W          3
`endif

// >>> rtl/ppss_sync.v
// two-flop synchroniser bank for asynchronous pins
`timescale 1ns/100ps
`default_nettype none
module ppss_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             i_mclk,
  input  wire             i_rst_n,
  // data
  input  wire [WIDTH-1:0] i_async,
  output reg  [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_reg;
  // first stage feeds only the second
  always @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      meta_reg <= {WIDTH{1'b0}};
      o_sync   <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= i_async;
      o_sync   <= meta_reg;
    end
  end
endmodule // ppss_sync
`default_nettype wire

// >>> tb/ppss_sequencer_monitor.sv
// concurrent checks on the power state sequencer ports
`timescale 1ns/100ps
`default_nettype none
module ppss_sequencer_monitor (
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_rst_n,
  // bus
  input wire logic       i_psel,
  input wire logic       i_penable,
  input wire logic       o_pslverr,
  // controls
  input wire logic       o_io_oe_n,
  input wire logic       o_analog_en,
  input wire logic       o_term_en,
  input wire logic       o_coding_en,
  input wire logic       o_send_sleep_codes,
  input wire logic       o_send_zero,
  input wire logic       o_energy_det_en,
  input wire logic [2:0] o_state
);
  // ==================================================
  // controls are registered from the next state on the same edge as o_state, so they do not lag it; the control checks still ask for two cycles in the state
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  AST_DOWN_OFF: assert property ((o_state == 3'h0) [*2] |-> o_io_oe_n && !o_analog_en)
    else $error("outputs active while powered down");
  AST_NO_TERM: assert property ((o_state == 3'h0 || o_state == 3'h6) [*2] |-> !o_term_en)
    else $error("termination present in reset or down");
  AST_STBY_OFF: assert property ((o_state == 3'h1) [*2] |-> !o_coding_en)
    else $error("coding enabled in standby");
  AST_SREQ_TX: assert property ((o_state == 3'h3) [*2] |-> o_send_sleep_codes)
    else $error("no sleep codes in sleep request");
  AST_SILENT_Z: assert property ((o_state == 3'h4) [*2] |-> o_send_zero && !o_send_sleep_codes)
    else $error("silent state not sending zero");
  AST_SLEEP_OFF: assert property ((o_state == 3'h5) [*2] |-> o_energy_det_en && !o_coding_en)
    else $error("wrong functions powered in sleep");
  AST_SLEEP_REFUSE: assert property (i_psel && i_penable && o_state == 3'h5 |-> o_pslverr)
    else $error("bus access accepted in sleep");
  AST_SILENT_EXIT: assert property (o_state == 3'h4 |=> o_state inside {0, 1, 4, 5, 6})
    else $error("illegal exit from silent");
  AST_SREQ_EXIT: assert property (o_state == 3'h3 |=> o_state inside {0, 2, 3, 4, 6})
    else $error("illegal exit from sleep request");
  AST_SLEEP_EXIT: assert property (o_state == 3'h5 |=> o_state inside {0, 5, 6})
    else $error("sleep left without reset");
  AST_RESET_EXIT: assert property (o_state == 3'h6 |=> o_state inside {0, 1, 2, 6})
    else $error("illegal exit from reset");
  cover property (o_state == 3'h5);
  cover property (o_state == 3'h4 ##1 o_state == 3'h1);
  cover property (o_state == 3'h3 ##1 o_state == 3'h2);
endmodule // ppss_sequencer_monitor
bind ppss_sequencer ppss_sequencer_monitor mon (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
  .i_psel(i_psel), .i_penable(i_penable), .o_pslverr(o_pslverr), .o_io_oe_n(o_io_oe_n),
  .o_analog_en(o_analog_en), .o_term_en(o_term_en), .o_coding_en(o_coding_en),
  .o_send_sleep_codes(o_send_sleep_codes), .o_send_zero(o_send_zero),
  .o_energy_det_en(o_energy_det_en), .o_state(o_state));
`default_nettype wire

// >>> tb/ppss_link_partner.sv
// behavioural far-end transceiver driving line events
`timescale 1ns/100ps
`default_nettype none
module ppss_link_partner (
  // clock and commands
  input  wire logic       i_mclk,
  input  wire logic [1:0] i_mode,
  input  wire logic       i_frame,
  // line events
  output var  logic       o_line_energy,
  output var  logic       o_line_quiet,
  output var  logic       o_rx_sleep_codes,
  output var  logic       o_frame_seen
);
  // ==================================================
  // mode 0 quiet line, 1 idle symbols, 2 sleep notice codes
  initial {o_line_energy, o_line_quiet, o_rx_sleep_codes, o_frame_seen} = 4'h4;
  always @(posedge i_mclk)
  begin
    o_line_energy    <= (i_mode != 2'h0);
    o_line_quiet     <= (i_mode == 2'h0);
    o_rx_sleep_codes <= (i_mode == 2'h2);
    o_frame_seen     <= i_frame && (i_mode != 2'h0);
  end
endmodule // ppss_link_partner
`default_nettype wire

// >>> tb/ppss_sequencer_tb.sv
// self-checking bench for the power state sequencer
`timescale 1ns/100ps
`default_nettype none
`include "ppss_defs.vh"
module ppss_sequencer_tb;
  localparam int SREQ = 20;
  localparam int SIL  = 50;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, serr, pready, pslverr;
  logic [12:0] padr = 13'h0;
  logic [31:0] pwd = 32'h0, rdat, prdata;
  logic        en_pin = 1'b1, wake = 1'b0, s_auto = 1'b0, s_mst = 1'b1, frame = 1'b0;
  logic [1:0]  pmode = 2'h0;
  logic        energy, quiet, rxc, fseen, term_en, oe_n, coding, sendz, codes, scr2, edet, mst;
  logic [2:0]  state;
  int          error_cnt = 0, cmp_count = 0, cyc = 0, waited;
  ppss_sequencer #(.SLEEP_REQ_CYC(SREQ), .SILENT_CYC(SIL)) uut (.i_mclk(i_mclk),
    .i_rst_n(i_rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
    .i_pwdata(pwd), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
    .i_supply_ok(1'b1), .i_enable_pin(en_pin), .i_wake_pin(wake), .i_strap_auto(s_auto),
    .i_strap_master(s_mst), .i_line_energy(energy), .i_line_quiet(quiet),
    .i_rx_sleep_codes(rxc), .i_frame_seen(fseen), .o_io_oe_n(oe_n), .o_analog_en(),
    .o_term_en(term_en), .o_coding_en(coding), .o_send_sleep_codes(codes),
    .o_send_zero(sendz), .o_scr_stream2(scr2), .o_energy_det_en(edet), .o_is_master(mst),
    .o_state(state));
  ppss_link_partner lp (.i_mclk(i_mclk), .i_mode(pmode), .i_frame(frame),
    .o_line_energy(energy), .o_line_quiet(quiet), .o_rx_sleep_codes(rxc),
    .o_frame_seen(fseen));
  // ==================================================
  // clock and hang guard
  always #5 i_mclk = ~i_mclk;
  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt++;
      conclude();
    end
  end
  // ==================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [12:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr  <= w;
    padr <= a;
    pwd  <= d;
    @(posedge i_mclk);
    pen <= 1'b1;
    do @(posedge i_mclk); while (pready !== 1'b1);
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
    @(posedge i_mclk);
  endtask
  // polls every edge so one-cycle states are still seen
  task automatic wst(input logic [2:0] s);
    waited = 0;
    while (state !== s && waited < 3000)
    begin
      @(posedge i_mclk);
      waited++;
    end
    chk(state, s);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    wst(3'h1);
    xfer(1'b0, `PPSS_ADDR_AUTO_CTRL, 32'h0);
    chk(rdat, 32'h3);
    xfer(1'b0, 13'h1ff0, 32'h0);
    chk(serr, 1'b1);
    xfer(1'b1, `PPSS_ADDR_SLEEP_CFG, 32'h300);
    repeat (2) @(posedge i_mclk);
    chk(scr2, 1'b1);
    xfer(1'b1, `PPSS_ADDR_POWER_MODE, 32'h1);
    wst(3'h2);
    // partner must be active, else a quiet line ends sleep request at once
    pmode <= 2'h1;
    xfer(1'b1, `PPSS_ADDR_POWER_MODE, 32'h2);
    wst(3'h3);
    repeat (2) @(posedge i_mclk);
    chk(codes, 1'b1);
    pmode <= 2'h1;
    frame <= 1'b1;
    wst(3'h2);
    frame <= 1'b0;
    pmode <= 2'h2;
    wst(3'h3);
    wst(3'h4);
    chk(waited >= SREQ - 4 && waited <= SREQ + 3, 1'b1);
    wst(3'h1);
    wst(3'h2);
    pmode <= 2'h0;
    xfer(1'b1, `PPSS_ADDR_POWER_MODE, 32'h2);
    wst(3'h4);
    wst(3'h5);
    chk(waited >= SIL - 3 && waited <= SIL + 3, 1'b1);
    xfer(1'b1, `PPSS_ADDR_AUTO_CTRL, 32'h0);
    chk(serr, 1'b1);
    chk(edet, 1'b1);
    wake <= 1'b1;
    wst(3'h6);
    wake <= 1'b0;
    wst(3'h1);
    xfer(1'b0, `PPSS_ADDR_SLEEP_CFG, 32'h0);
    chk(rdat, 32'h0);
    xfer(1'b1, `PPSS_ADDR_AUTO_CTRL, 32'h1);
    xfer(1'b1, `PPSS_ADDR_POWER_MODE, 32'h1);
    wst(3'h2);
    // wake held high keeps the expired request from going silent
    wake <= 1'b1;
    xfer(1'b1, `PPSS_ADDR_POWER_MODE, 32'h2);
    repeat (30) @(posedge i_mclk);
    chk(state, 3'h3);
    wake <= 1'b0;
    wst(3'h4);
    wst(3'h1);
    chk(waited >= SIL - 3 && waited <= SIL + 3, 1'b1);
    xfer(1'b1, `PPSS_ADDR_AUTO_CTRL, 32'h41);
    wst(3'h2);
    xfer(1'b1, `PPSS_ADDR_RESET_CTRL, 32'h8000);
    wst(3'h1);
    xfer(1'b0, `PPSS_ADDR_AUTO_CTRL, 32'h0);
    chk(rdat, 32'h3);
    en_pin <= 1'b0;
    wst(3'h0);
    repeat (2) @(posedge i_mclk);
    chk({term_en, oe_n}, 2'b01);
    s_auto <= 1'b1;
    en_pin <= 1'b1;
    wst(3'h2);
    xfer(1'b0, `PPSS_ADDR_STATUS, 32'h0);
    chk(rdat[7:0], 8'hc2);
    chk(mst, 1'b1);
    conclude();
  end
endmodule // ppss_sequencer_tb
`default_nettype wire
